// [inc/ead_defs.vh]
/*
 * Constants of the external area decoder: register offsets, reset values,
 * field positions and area codes.
 * Assumes it is included by bare name from core files; definitions only.
 */
`ifndef EAD_DEFS_VH
`define EAD_DEFS_VH

// Register indices; the AXI byte address carries the index shifted by two.
`define EAD_OFS_ROM_SELECT_CTRL_0 32'hFFFFFF50
`define EAD_OFS_ROM_SELECT_CTRL_1 32'hFFFFFF52
`define EAD_OFS_ROM_SELECT_CTRL_2 32'hFFFFFF54
`define EAD_OFS_ROM_SELECT_CTRL_3 32'h0FFFFF56
`define EAD_OFS_ROM_SELECT_CTRL_4 32'h0FFFFF58
`define EAD_OFS_ROM_SELECT_CTRL_5 32'h0FFFFF5A
`define EAD_OFS_ROM_SELECT_CTRL_6 32'h0FFFFF5C
`define EAD_OFS_ROM_SELECT_CTRL_7 32'hFFFFFF5E
`define EAD_OFS_BUS_CONTROL_1 32'hFFFFFF60
`define EAD_OFS_BUS_CONTROL_2 32'hFFFFFF62
`define EAD_OFS_WAIT_CONTROL_1 32'hFFFFFF64
`define EAD_OFS_WAIT_CONTROL_2 32'hFFFFFF66
`define EAD_OFS_MEMORY_CONTROL 32'hFFFFFF68
`define EAD_OFS_CARD_INTERFACE_CONTROL 32'hFFFFFF6C
`define EAD_OFS_REFRESH_TIMER_CTRL_STATUS 32'hFFFFFF6E
`define EAD_OFS_REFRESH_TIMER_COUNTER 32'hFFFFFF70
`define EAD_OFS_REFRESH_TIME_CONSTANT 32'hFFFFFF72
`define EAD_OFS_REFRESH_EVENT_COUNT 32'hFFFFFF74
`define EAD_OFS_DECODE_STATUS 32'hFFFFFF76
`define EAD_OFS_SDRAM_MODE_AREA2 32'hFFFFD000
`define EAD_OFS_SDRAM_MODE_AREA3 32'hFFFFE000

// Reset values: three that differ from zero, then the common zero.
`define EAD_RST_BUS_CONTROL_2 16'h3FF0
`define EAD_RST_WAIT_CONTROL_1 16'h3FF3
`define EAD_RST_WAIT_CONTROL_2 16'hFFFF
`define EAD_RST_ZERO 16'h0000

// Field positions.
`define EAD_BC1_AREA5_CARD 1
`define EAD_BC1_AREA6_CARD 0
`define EAD_BC2_WIDTH_LSB 4

// Area codes taken from address bits 28 to 26.
`define EAD_AREA_MSB 28
`define EAD_AREA_LSB 26
`define EAD_HALF_BIT 25
`define EAD_AREA0 3'h0
`define EAD_AREA2 3'h2
`define EAD_AREA3 3'h3
`define EAD_AREA4 3'h4
`define EAD_AREA5 3'h5
`define EAD_AREA6 3'h6

// Register file layout and AXI answers.
`define EAD_SLOTS 19
`define EAD_SLOT_NONE 5'h1F
`define EAD_SLOT_STATUS 5'h12
`define EAD_RESP_OKAY 2'h0
`define EAD_RESP_SLVERR 2'h2

`endif

// [core/ead_decoder.v]
/*
 * External area decoder: AXI4-Lite register file of the bus state unit and
 * registered area decode driving the chip selects and card enables.
 * Assumes the core presents each bus cycle on cycleActive/cycleAddr/cycleByteEn
 * synchronous to mclk, and the width straps are stable around reset release.
 */
// Local design decision: the AXI4-Lite slave port.
`include "ead_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ead_decoder (
	input wire mclk,
	input wire reset_n,
	input wire width_strap_hi,
	input wire width_strap_lo,
	input wire cycleActive,
	input wire [31:0] cycleAddr,
	input wire [3:0] cycleByteEn,
	output reg area0_select_n,
	output reg area2_select_n,
	output reg area3_select_n,
	output reg area4_select_n,
	output reg area5_select_n,
	output reg area6_select_n,
	output reg card_a_enable_hi_n,
	output reg card_b_enable_hi_n,
	output reg [1:0] areaWidth,
	output reg cardIoSpace,
	output reg [1:0] sdramModeStrobe,
	output reg [11:0] sdramModeAddr,
	output reg [7:0] sdramModeData,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// Maps a register index (byte address bits 15:2) to its storage slot.
	function [4:0] slotOf;
		input [13:0] idx;
		begin
			case (idx)
				`EAD_OFS_ROM_SELECT_CTRL_0 & 32'h3FFF: slotOf = 5'h00;
				`EAD_OFS_ROM_SELECT_CTRL_1 & 32'h3FFF: slotOf = 5'h01;
				`EAD_OFS_ROM_SELECT_CTRL_2 & 32'h3FFF: slotOf = 5'h02;
				`EAD_OFS_ROM_SELECT_CTRL_3 & 32'h3FFF: slotOf = 5'h03;
				`EAD_OFS_ROM_SELECT_CTRL_4 & 32'h3FFF: slotOf = 5'h04;
				`EAD_OFS_ROM_SELECT_CTRL_5 & 32'h3FFF: slotOf = 5'h05;
				`EAD_OFS_ROM_SELECT_CTRL_6 & 32'h3FFF: slotOf = 5'h06;
				`EAD_OFS_ROM_SELECT_CTRL_7 & 32'h3FFF: slotOf = 5'h07;
				`EAD_OFS_BUS_CONTROL_1 & 32'h3FFF: slotOf = 5'h08;
				`EAD_OFS_BUS_CONTROL_2 & 32'h3FFF: slotOf = 5'h09;
				`EAD_OFS_WAIT_CONTROL_1 & 32'h3FFF: slotOf = 5'h0A;
				`EAD_OFS_WAIT_CONTROL_2 & 32'h3FFF: slotOf = 5'h0B;
				`EAD_OFS_MEMORY_CONTROL & 32'h3FFF: slotOf = 5'h0C;
				`EAD_OFS_CARD_INTERFACE_CONTROL & 32'h3FFF: slotOf = 5'h0D;
				`EAD_OFS_REFRESH_TIMER_CTRL_STATUS & 32'h3FFF: slotOf = 5'h0E;
				`EAD_OFS_REFRESH_TIMER_COUNTER & 32'h3FFF: slotOf = 5'h0F;
				`EAD_OFS_REFRESH_TIME_CONSTANT & 32'h3FFF: slotOf = 5'h10;
				`EAD_OFS_REFRESH_EVENT_COUNT & 32'h3FFF: slotOf = 5'h11;
				`EAD_OFS_DECODE_STATUS & 32'h3FFF: slotOf = `EAD_SLOT_STATUS;
				default: slotOf = `EAD_SLOT_NONE;
			endcase
		end
	endfunction

	// Power-on value of each storage slot.
	function [15:0] resetOf;
		input [4:0] slot;
		begin
			case (slot)
				5'h09: resetOf = `EAD_RST_BUS_CONTROL_2;
				5'h0A: resetOf = `EAD_RST_WAIT_CONTROL_1;
				5'h0B: resetOf = `EAD_RST_WAIT_CONTROL_2;
				default: resetOf = `EAD_RST_ZERO;
			endcase
		end
	endfunction

	reg [15:0] regFile_q [0:`EAD_SLOTS-2];
	reg [13:0] wrIdx_q;
	reg [15:0] wrData_q;
	reg [1:0] wrStrb_q;
	reg wrByte0_q;
	reg awHave_q;
	reg wHave_q;
	reg strapTaken_q;
	reg [1:0] area0Width_q;
	reg [2:0] lastArea_q;
	wire [4:0] wrSlot;
	wire [4:0] rdSlot;
	wire [13:0] rdIdx;
	wire wrWindow2;
	wire wrWindow3;
	wire doWrite;
	wire [15:0] busCtrl1;
	wire [15:0] busCtrl2;
	wire [2:0] area;
	wire upperBytes;
	reg [1:0] widthSel;
	integer i;
	localparam [31:0] WINDOW2_IDX = `EAD_OFS_SDRAM_MODE_AREA2;
	localparam [31:0] WINDOW3_IDX = `EAD_OFS_SDRAM_MODE_AREA3;
	wire [15:0] widthField;

	assign wrSlot = slotOf(wrIdx_q);
	assign rdIdx = s_axi_araddr[15:2];
	assign rdSlot = slotOf(rdIdx);
	// SDRAM mode windows: index bits 13:12 are 01 for area 2 and 10 for area 3.
	assign wrWindow2 = (wrIdx_q[13:12] == WINDOW2_IDX[13:12]);
	assign wrWindow3 = (wrIdx_q[13:12] == WINDOW3_IDX[13:12]);
	assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
	assign busCtrl1 = regFile_q[8];
	assign busCtrl2 = regFile_q[9];

	// Write address and write data are taken independently, in either order.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			wrIdx_q <= 14'h0000;
			wrData_q <= 16'h0000;
			wrStrb_q <= 2'h0;
			wrByte0_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_q <= 1'b1;
				s_axi_awready <= 1'b0;
				wrIdx_q <= s_axi_awaddr[15:2];
			end else if (doWrite) begin
				awHave_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_q <= 1'b1;
				s_axi_wready <= 1'b0;
				wrData_q <= s_axi_wdata[15:0];
				wrStrb_q <= s_axi_wstrb[1:0];
				wrByte0_q <= s_axi_wstrb[0];
			end else if (doWrite) begin
				wHave_q <= 1'b0;
			end
			// Ready returns only after the response is taken, so one write is open.
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Register storage, write response and SDRAM mode commands.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (i = 0; i < `EAD_SLOTS - 1; i = i + 1) begin
				regFile_q[i] <= resetOf(i[4:0]);
			end
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `EAD_RESP_OKAY;
			sdramModeStrobe <= 2'h0;
			sdramModeAddr <= 12'h000;
			sdramModeData <= 8'h00;
		end else begin
			sdramModeStrobe <= 2'h0;
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `EAD_RESP_OKAY;
				if (wrSlot == `EAD_SLOT_STATUS) begin
					s_axi_bresp <= `EAD_RESP_OKAY;
				end else if (wrSlot != `EAD_SLOT_NONE) begin
					if (wrStrb_q[0]) begin
						regFile_q[wrSlot][7:0] <= wrData_q[7:0];
					end
					if (wrStrb_q[1]) begin
						regFile_q[wrSlot][15:8] <= wrData_q[15:8];
					end
				end else if ((wrWindow2 || wrWindow3) && wrByte0_q) begin
					// The window offset itself is the mode word the memory sees.
					sdramModeStrobe <= {wrWindow3, wrWindow2};
					sdramModeAddr <= wrIdx_q[11:0];
					sdramModeData <= wrData_q[7:0];
				end else begin
					s_axi_bresp <= `EAD_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one read at a time, answered one cycle after the address.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `EAD_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `EAD_RESP_OKAY;
				s_axi_rdata <= 32'h00000000;
				if (rdSlot == `EAD_SLOT_STATUS) begin
					s_axi_rdata <= {27'h0000000, lastArea_q, area0Width_q};
				end else if (rdSlot != `EAD_SLOT_NONE) begin
					s_axi_rdata <= {16'h0000, regFile_q[rdSlot]};
				end else begin
					// Mode windows are write-only and read back as an error.
					s_axi_rresp <= `EAD_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// The straps are sampled once, at the first edge after reset release.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			strapTaken_q <= 1'b0;
			area0Width_q <= 2'h0;
		end else if (!strapTaken_q) begin
			strapTaken_q <= 1'b1;
			area0Width_q <= {width_strap_hi, width_strap_lo};
		end
	end

	// Bits 31:29 never enter the decode, so every shadow copy maps alike.
	assign area = cycleAddr[`EAD_AREA_MSB:`EAD_AREA_LSB];
	assign upperBytes = cycleByteEn[1] || cycleByteEn[3];
	// Only the low two bits of the shifted control word are the width field.
	assign widthField = busCtrl2 >> (`EAD_BC2_WIDTH_LSB + 2 * (area - `EAD_AREA2));

	always @* begin
		case (area)
			`EAD_AREA0: widthSel = area0Width_q;
			`EAD_AREA2, `EAD_AREA3, `EAD_AREA4, `EAD_AREA5, `EAD_AREA6:
				widthSel = widthField[1:0];
			default: widthSel = 2'h0;
		endcase
	end

	// Registered decode: each select is a flop, asserted one cycle after the
	// cycle is presented. Area 1 and area 7 drive no external select.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			area0_select_n <= 1'b1;
			area2_select_n <= 1'b1;
			area3_select_n <= 1'b1;
			area4_select_n <= 1'b1;
			area5_select_n <= 1'b1;
			area6_select_n <= 1'b1;
			card_a_enable_hi_n <= 1'b1;
			card_b_enable_hi_n <= 1'b1;
			areaWidth <= 2'h0;
			cardIoSpace <= 1'b0;
			lastArea_q <= 3'h0;
		end else begin
			area0_select_n <= !(cycleActive && area == `EAD_AREA0);
			area2_select_n <= !(cycleActive && area == `EAD_AREA2);
			area3_select_n <= !(cycleActive && area == `EAD_AREA3);
			area4_select_n <= !(cycleActive && area == `EAD_AREA4);
			area5_select_n <= !(cycleActive && area == `EAD_AREA5);
			area6_select_n <= !(cycleActive && area == `EAD_AREA6);
			card_a_enable_hi_n <= !(cycleActive && area == `EAD_AREA5 &&
				busCtrl1[`EAD_BC1_AREA5_CARD] && upperBytes);
			card_b_enable_hi_n <= !(cycleActive && area == `EAD_AREA6 &&
				busCtrl1[`EAD_BC1_AREA6_CARD] && upperBytes);
			areaWidth <= cycleActive ? widthSel : 2'h0;
			// The upper 32-Mbyte half of a card area is its I/O space.
			cardIoSpace <= cycleActive && cycleAddr[`EAD_HALF_BIT] &&
				((area == `EAD_AREA5 && busCtrl1[`EAD_BC1_AREA5_CARD]) ||
				(area == `EAD_AREA6 && busCtrl1[`EAD_BC1_AREA6_CARD]));
			if (cycleActive) begin
				lastArea_q <= area;
			end
		end
	end

endmodule // ead_decoder

`default_nettype wire

// [verification/ead_decoder_monitor.sv]
/* Checker of the area decoder's selects, card enables and write answers.
   Assumes it is bound to ead_decoder and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module ead_decoder_monitor (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic cycleActive,
	input wire logic [31:0] cycleAddr,
	input wire logic [3:0] cycleByteEn,
	input wire logic area0_select_n,
	input wire logic area2_select_n,
	input wire logic area3_select_n,
	input wire logic area4_select_n,
	input wire logic area5_select_n,
	input wire logic area6_select_n,
	input wire logic card_a_enable_hi_n,
	input wire logic card_b_enable_hi_n,
	input wire logic [1:0] areaWidth,
	input wire logic [1:0] sdramModeStrobe,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	logic [5:0] selOn;
	assign selOn = ~{area6_select_n, area5_select_n, area4_select_n, area3_select_n, area2_select_n, area0_select_n};
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	chk_area_five: assert property (cycleActive && cycleAddr[28:26] == 3'h5 |=> selOn == 6'h10)
		else $error("area 5 cycle did not select area 5 alone");
	chk_shadow_ignore: assert property (cycleActive && cycleAddr[28:26] == 3'h0 |=> selOn == 6'h01)
		else $error("area 0 cycle did not select area 0 alone");
	chk_single_select: assert property ($onehot0(selOn))
		else $error("two selects low together");
	chk_idle_quiet: assert property (!cycleActive |=> selOn == 6'h00 && card_a_enable_hi_n && card_b_enable_hi_n)
		else $error("select low outside a cycle");
	chk_hole_quiet: assert property (cycleActive && cycleAddr[28:26] == 3'h1 |=> selOn == 6'h00 && card_a_enable_hi_n && card_b_enable_hi_n)
		else $error("area 1 cycle asserted a select");
	chk_card_slot: assert property ((card_a_enable_hi_n || !area5_select_n) && (card_b_enable_hi_n || !area6_select_n))
		else $error("card enable without its area select");
	chk_card_lanes: assert property (cycleActive && !cycleByteEn[1] && !cycleByteEn[3] |=> card_a_enable_hi_n && card_b_enable_hi_n)
		else $error("upper card enable without upper lanes");
	chk_mode_pulse: assert property (sdramModeStrobe != 2'h0 |=> sdramModeStrobe == 2'h0)
		else $error("mode strobe longer than one cycle");
	chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
endmodule // ead_decoder_monitor
bind ead_decoder ead_decoder_monitor mon (.*);
`default_nettype wire

// [verification/ead_far_side.sv]
/* Far-side card slots: counts accesses seen with a card enable and its area select both low.
   Assumes the decoder's active-low selects and card enables, one clock. */
`timescale 1ns/1ps
`default_nettype none
module ead_far_side (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic area5_select_n,
	input wire logic area6_select_n,
	input wire logic card_a_enable_hi_n,
	input wire logic card_b_enable_hi_n,
	output var logic [7:0] cardHits
);
	// A slot answers only when both of its enables are low, as a real card does.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cardHits <= 8'h00;
		end else if ((!area5_select_n && !card_a_enable_hi_n) || (!area6_select_n && !card_b_enable_hi_n)) begin
			cardHits <= cardHits + 8'h01;
		end
	end
endmodule // ead_far_side
`default_nettype wire

// [verification/tb_top.sv]
/* Bench of the area decoder: registers over AXI4-Lite, then decode cycles.
   Assumes ead_decoder, ead_far_side and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic mclk, reset_n, width_strap_hi, width_strap_lo, cycleActive, cardIoSpace;
	logic [31:0] cycleAddr, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0] cycleByteEn, s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic area0_select_n, area2_select_n, area3_select_n, area4_select_n, area5_select_n, area6_select_n;
	logic card_a_enable_hi_n, card_b_enable_hi_n;
	logic [1:0] areaWidth, sdramModeStrobe, s_axi_bresp, s_axi_rresp, rs, stbSeen = 2'h0;
	logic [11:0] sdramModeAddr;
	logic [7:0] sdramModeData, cardHits;
	int miscompares = 0, testsRun = 0, cycles = 0;
	logic [31:0] idx [5] = '{32'hFFFFFF60, 32'hFFFFFF62, 32'hFFFFFF64, 32'hFFFFFF66, 32'h0FFFFF56};
	logic [15:0] rstVal [5] = '{16'h0000, 16'h3FF0, 16'h3FF3, 16'hFFFF, 16'h0000};
	// Areas 2 and 3 share 16 bits as SDRAM needs; card areas stay at 8 and 16 bits.
	localparam logic [15:0] AREA_WIDTHS = 16'h27A0;
	wire [10:0] seen = {cardIoSpace, card_b_enable_hi_n, card_a_enable_hi_n, areaWidth, area6_select_n,
		area5_select_n, area4_select_n, area3_select_n, area2_select_n, area0_select_n};
	ead_decoder uut (.*);
	ead_far_side far (.*);
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task close_out;
		if (miscompares == 0 && testsRun > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge mclk) begin
		if (sdramModeStrobe != 2'h0) stbSeen <= sdramModeStrobe;
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares = miscompares + 1;
			close_out();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun = testsRun + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask
	task axiWr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge mclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task axiRd(input logic [31:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		{rd, rs} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
	// One active cycle, then idle; outputs show the active sample one edge later.
	task dec(input logic [31:0] a, input logic [3:0] be, input logic [10:0] exp);
		@(posedge mclk);
		{cycleActive, cycleAddr, cycleByteEn} <= {1'b1, a, be};
		@(posedge mclk);
		cycleActive <= 1'b0;
		#1;
		chk({21'h0, seen}, {21'h0, exp});
	endtask
	function automatic logic [5:0] selFor(input int c);
		return (c == 0) ? 6'h3E : (c >= 2 && c <= 6) ? ~(6'h01 << (c - 1)) : 6'h3F;
	endfunction
	function automatic logic [1:0] widthFor(input int c);
		return (c == 0) ? 2'h1 : (c >= 2 && c <= 6) ? 2'(AREA_WIDTHS >> (4 + 2 * (c - 2))) : 2'h0;
	endfunction
	initial begin
		{reset_n, width_strap_hi, cycleActive, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
		{s_axi_arvalid, s_axi_rready, cycleByteEn, s_axi_wstrb} = 10'h000;
		{cycleAddr, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 128'h0;
		width_strap_lo = 1'b1;
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			axiRd(idx[i] << 2);
			chk(rd, {16'h0, rstVal[i]});
		end
		axiWr(32'hFFFFFF62 << 2, {16'h0, AREA_WIDTHS}, 4'h3);
		axiRd(32'hFFFFFF62 << 2);
		chk(rd, {16'h0, AREA_WIDTHS});
		axiWr(32'hFFFFFF60 << 2, 32'h3, 4'h3);
		axiWr(32'hFFFFFF6A << 2, 32'h1, 4'h3);
		chk({30'h0, rs}, 32'h2);
		axiWr(32'hFFFFD010 << 2, 32'hA5, 4'h1);
		#1;
		chk({10'h0, stbSeen, sdramModeAddr, sdramModeData}, {10'h0, 2'h1, 12'h010, 8'hA5});
		axiWr(32'hFFFFE020 << 2, 32'h5A, 4'h1);
		#1;
		chk({10'h0, stbSeen, sdramModeAddr, sdramModeData}, {10'h0, 2'h2, 12'h020, 8'h5A});
		axiWr(32'hFFFFD004 << 2, 32'h77, 4'h2);
		chk({30'h0, rs}, 32'h2);
		axiRd(32'hFFFFD010 << 2);
		chk({30'h0, rs}, 32'h2);
		for (int c = 0; c < 7; c++) begin
			dec({c[2:0], c[2:0], 26'h0001234}, 4'h1, {3'b011, widthFor(c), selFor(c)});
		end
		dec(32'h16000000, 4'h2, {3'b110, widthFor(5), selFor(5)});
		dec(32'hF8000000, 4'h8, {3'b001, widthFor(6), selFor(6)});
		@(posedge mclk);
		#1;
		chk({24'h0, cardHits}, 32'h2);
		axiWr(32'hFFFFFF60 << 2, 32'h0, 4'h3);
		dec(32'h16000000, 4'h2, {3'b011, widthFor(5), selFor(5)});
		axiRd(32'hFFFFFF76 << 2);
		chk(rd, 32'h15);
		@(posedge mclk);
		{reset_n, width_strap_hi} <= 2'h1;
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		dec(32'h20000010, 4'hF, {3'b011, 2'h3, selFor(0)});
		axiRd(32'hFFFFFF62 << 2);
		chk(rd, 32'h3FF0);
		axiRd(32'hFFFFFF76 << 2);
		chk(rd, 32'h3);
		close_out();
	end
endmodule // tb_top
`default_nettype wire
